// ===== src/usbes_pkg.sv
// Shared constants and types for endpoint selection and configuration
package usbes_pkg;
   // ==========================================================
   // Register map; byte address is four times the register index
   localparam logic [7:0] USBES_IDX_REG = 8'hc7;
   localparam logic [7:0] USBES_CTL_REG = 8'hd4;
   localparam logic [11:0] USBES_IDX_ADDR = {2'h0, USBES_IDX_REG, 2'h0};
   localparam logic [11:0] USBES_CTL_ADDR = {2'h0, USBES_CTL_REG, 2'h0};
   localparam logic [11:0] USBES_IRQ_STAT_ADDR = 12'h400;
   localparam logic [11:0] USBES_IRQ_MASK_ADDR = 12'h404;
   // ==========================================================
   // Control register fields
   localparam int USBES_ON_BIT = 7;
   localparam int USBES_IEN_BIT = 6;
   localparam int USBES_ROUT_BIT = 5;
   localparam int USBES_RIN_BIT = 4;
   localparam int USBES_TGL_BIT = 3;
   localparam int USBES_DIR_BIT = 2;
   localparam int USBES_TYPE_LO = 0;
   localparam logic [7:0] USBES_CTL_RESET = 8'h00;
   localparam logic [7:0] USBES_IDX_MASK = 8'h03;
   localparam logic [3:0] USBES_IRQ_RESET = 4'h0;
   localparam int USBES_NUM_EP = 4;
   // ==========================================================
   // Host timeout while waiting for a handshake
   localparam logic [3:0] USBES_HOST_TIMEOUT = 4'h8;

   typedef enum logic [1:0] {
      USBES_TYPE_CONTROL = 2'h0,
      USBES_TYPE_ISO = 2'h1,
      USBES_TYPE_BULK = 2'h2,
      USBES_TYPE_INTR = 2'h3
   } usbes_type_t;

   typedef enum logic [1:0] {
      USBES_HS_NONE = 2'h0,
      USBES_HS_ACK = 2'h1,
      USBES_HS_NAK = 2'h2,
      USBES_HS_STALL = 2'h3
   } usbes_hs_t;

   typedef struct packed {
      logic on;
      logic irq_en;
      logic ref_out;
      logic ref_in;
      logic toggle;
      logic dir;
      usbes_type_t ttype;
   } usbes_ctl_t;
endpackage

// ===== src/usbes_link_if.sv
// Transaction-level link between the USB host and the device endpoint logic
`timescale 1ns/1ps
interface usbes_link_if;
   import usbes_pkg::*;
   logic bus_reset;
   logic tok_valid;
   logic tok_in;
   logic [1:0] tok_ep;
   logic tok_data1;
   logic hs_valid;
   usbes_hs_t hs_code;

   modport dev (
      input bus_reset,
      input tok_valid,
      input tok_in,
      input tok_ep,
      input tok_data1,
      output hs_valid,
      output hs_code
   );
   modport host (
      output bus_reset,
      output tok_valid,
      output tok_in,
      output tok_ep,
      output tok_data1,
      input hs_valid,
      input hs_code
   );
endinterface

// ===== src/usbes_sticky.sv
// Sticky flag where a hardware set wins over a software clear
`timescale 1ns/1ps
module usbes_sticky (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic sync_clr,
   input wire logic set,
   input wire logic clr,
   output logic flag_q
);
   import usbes_pkg::*;
   // ==========================================================
   // Flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flag_q <= 1'b0;
      end else if (sync_clr) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end
endmodule

// ===== src/usbes_dev.sv
// Device end: endpoint index, per-endpoint control registers and handshakes
//
// Contract
// - Index field picks endpoint for register access
// - Index upper bits read zero, never written
// - Endpoint-on bit activates or deactivates endpoint
// - Software enables endpoint 0 after resets
// - Endpoint 0 resets to control type; software may write any type
// - NAK on OUT sets refused-out flag, irq
// - Refused-out flag cleared by software or bus reset
// - Direction one means IN, zero OUT
// - Control endpoints ignore the direction bit
// - Type field: 00 control, 01 iso, 10 bulk
`timescale 1ns/1ps
module usbes_dev (
   input wire logic sys_clk,
   input wire logic nrst,
   usbes_link_if.dev link,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [usbes_pkg::USBES_NUM_EP-1:0] ep_ready,
   output logic [usbes_pkg::USBES_NUM_EP-1:0] ep_active,
   output logic irq
);
   import usbes_pkg::*;

   logic [1:0] idx_q;
   usbes_ctl_t cfg_q [USBES_NUM_EP];
   logic [USBES_NUM_EP-1:0] tgl_q;
   logic [USBES_NUM_EP-1:0] rout_q;
   logic [USBES_NUM_EP-1:0] rin_q;
   logic [USBES_NUM_EP-1:0] set_out;
   logic [USBES_NUM_EP-1:0] set_in;
   logic [USBES_NUM_EP-1:0] clr_out;
   logic [USBES_NUM_EP-1:0] clr_in;
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic ws_q;
   logic acc;
   logic wr_go;
   logic hs_valid_q;
   usbes_hs_t hs_code_q;
   usbes_hs_t hs_d;
   usbes_ctl_t tcfg;
   usbes_ctl_t scfg;

   function automatic logic [7:0] ctl_pack(input usbes_ctl_t c);
      ctl_pack = c;
   endfunction

   // ==========================================================
   // Avalon slave, one wait state on every access
   assign acc = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ws_q;
   assign wr_go = avs_write & ws_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ws_q <= 1'b0;
      end else begin
         ws_q <= acc & ~ws_q;
      end
   end

   // Selected endpoint view with live flags
   always_comb begin
      scfg = cfg_q[idx_q];
      scfg.ref_out = rout_q[idx_q];
      scfg.ref_in = rin_q[idx_q];
      scfg.toggle = tgl_q[idx_q];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~ws_q) begin
         case (avs_address)
            USBES_IDX_ADDR: avs_readdata <= {30'h0, idx_q};
            USBES_CTL_ADDR: avs_readdata <= {24'h0, ctl_pack(scfg)};
            USBES_IRQ_STAT_ADDR: avs_readdata <= {28'h0, stat_q};
            USBES_IRQ_MASK_ADDR: avs_readdata <= {28'h0, mask_q};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Endpoint index
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         idx_q <= 2'h0;
      end else if (wr_go && avs_byteenable[0] && avs_address == USBES_IDX_ADDR) begin
         idx_q <= avs_writedata[1:0];
      end
   end

   // ==========================================================
   // Endpoint configuration, cleared by hardware or bus reset
   // Endpoint 0 is left off after reset; firmware must turn it on as control
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < USBES_NUM_EP; i++) begin
            cfg_q[i] <= USBES_CTL_RESET;
         end
      end else if (link.bus_reset) begin
         for (int i = 0; i < USBES_NUM_EP; i++) begin
            cfg_q[i] <= USBES_CTL_RESET;
         end
      end else if (wr_go && avs_byteenable[0] && avs_address == USBES_CTL_ADDR) begin
         cfg_q[idx_q].on <= avs_writedata[USBES_ON_BIT];
         cfg_q[idx_q].irq_en <= avs_writedata[USBES_IEN_BIT];
         cfg_q[idx_q].dir <= avs_writedata[USBES_DIR_BIT];
         cfg_q[idx_q].ttype <= usbes_type_t'(avs_writedata[USBES_TYPE_LO +: 2]);
      end
   end

   always_comb begin
      for (int i = 0; i < USBES_NUM_EP; i++) begin
         ep_active[i] = cfg_q[i].on;
         clr_out[i] = wr_go && avs_byteenable[0] && avs_address == USBES_CTL_ADDR &&
                      idx_q == i[1:0] && !avs_writedata[USBES_ROUT_BIT];
         clr_in[i] = wr_go && avs_byteenable[0] && avs_address == USBES_CTL_ADDR &&
                     idx_q == i[1:0] && !avs_writedata[USBES_RIN_BIT];
      end
   end

   // ==========================================================
   // Token handling
   always_comb begin
      tcfg = cfg_q[link.tok_ep];
      if (!tcfg.on) begin
         hs_d = USBES_HS_NONE;
      end else if (tcfg.ttype != USBES_TYPE_CONTROL && tcfg.dir != link.tok_in) begin
         hs_d = USBES_HS_STALL;
      end else if (ep_ready[link.tok_ep]) begin
         hs_d = USBES_HS_ACK;
      end else begin
         hs_d = USBES_HS_NAK;
      end
      for (int i = 0; i < USBES_NUM_EP; i++) begin
         set_out[i] = link.tok_valid && link.tok_ep == i[1:0] && !link.tok_in &&
                      hs_d == USBES_HS_NAK;
         set_in[i] = link.tok_valid && link.tok_ep == i[1:0] && link.tok_in &&
                     hs_d == USBES_HS_NAK;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hs_valid_q <= 1'b0;
         hs_code_q <= USBES_HS_NONE;
      end else begin
         hs_valid_q <= link.tok_valid & ~link.bus_reset;
         hs_code_q <= link.tok_valid ? hs_d : USBES_HS_NONE;
      end
   end
   assign link.hs_valid = hs_valid_q;
   assign link.hs_code = hs_code_q;

   // Toggle follows accepted OUT data only; a refused packet is not seen
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tgl_q <= '0;
      end else if (link.bus_reset) begin
         tgl_q <= '0;
      end else if (link.tok_valid && !link.tok_in && hs_d == USBES_HS_ACK) begin
         tgl_q[link.tok_ep] <= link.tok_data1;
      end
   end

   // ==========================================================
   // Refusal flags, hardware set wins over software clear
   for (genvar g = 0; g < USBES_NUM_EP; g++) begin : g_flags
      usbes_sticky u_out (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .sync_clr(link.bus_reset),
         .set(set_out[g]),
         .clr(clr_out[g]),
         .flag_q(rout_q[g])
      );
      usbes_sticky u_in (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .sync_clr(link.bus_reset),
         .set(set_in[g]),
         .clr(clr_in[g]),
         .flag_q(rin_q[g])
      );
   end

   // ==========================================================
   // Interrupt status, write one to clear, set wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stat_q <= USBES_IRQ_RESET;
      end else begin
         for (int i = 0; i < USBES_NUM_EP; i++) begin
            if ((set_out[i] | set_in[i]) & cfg_q[i].irq_en) begin
               stat_q[i] <= 1'b1;
            end else if (wr_go && avs_byteenable[0] && avs_address == USBES_IRQ_STAT_ADDR &&
                         avs_writedata[i]) begin
               stat_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= USBES_IRQ_RESET;
      end else if (wr_go && avs_byteenable[0] && avs_address == USBES_IRQ_MASK_ADDR) begin
         mask_q <= avs_writedata[3:0];
      end
   end

   assign irq = |(stat_q & mask_q);
endmodule

// ===== src/usbes_host.sv
// Host end: issues tokens and bus resets, reports the device handshake
`timescale 1ns/1ps
module usbes_host (
   input wire logic sys_clk,
   input wire logic nrst,
   usbes_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_reset,
   input wire logic cmd_in,
   input wire logic [1:0] cmd_ep,
   input wire logic cmd_data1,
   output logic res_valid,
   output usbes_pkg::usbes_hs_t res_code
);
   import usbes_pkg::*;

   typedef enum logic [1:0] {USBES_H_IDLE, USBES_H_TOKEN, USBES_H_WAIT} usbes_hstate_t;
   usbes_hstate_t st_q;
   logic [3:0] tmo_q;
   logic rst_q;
   logic in_q;
   logic [1:0] ep_q;
   logic d1_q;

   assign cmd_ready = (st_q == USBES_H_IDLE);
   assign link.bus_reset = rst_q;
   assign link.tok_valid = (st_q == USBES_H_TOKEN);
   assign link.tok_in = in_q;
   assign link.tok_ep = ep_q;
   assign link.tok_data1 = d1_q;

   // ==========================================================
   // Sequencer; endpoint 0 setup after a reset is firmware's job
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= USBES_H_IDLE;
         tmo_q <= 4'h0;
         rst_q <= 1'b0;
         in_q <= 1'b0;
         ep_q <= 2'h0;
         d1_q <= 1'b0;
         res_valid <= 1'b0;
         res_code <= USBES_HS_NONE;
      end else begin
         res_valid <= 1'b0;
         rst_q <= 1'b0;
         case (st_q)
            USBES_H_IDLE: begin
               if (cmd_valid && cmd_reset) begin
                  rst_q <= 1'b1;
               end else if (cmd_valid) begin
                  in_q <= cmd_in;
                  ep_q <= cmd_ep;
                  d1_q <= cmd_data1;
                  st_q <= USBES_H_TOKEN;
               end
            end
            USBES_H_TOKEN: begin
               tmo_q <= 4'h0;
               st_q <= USBES_H_WAIT;
            end
            USBES_H_WAIT: begin
               tmo_q <= tmo_q + 4'h1;
               if (link.hs_valid) begin
                  res_valid <= 1'b1;
                  res_code <= link.hs_code;
                  st_q <= USBES_H_IDLE;
               end else if (tmo_q == USBES_HOST_TIMEOUT) begin
                  res_valid <= 1'b1;
                  res_code <= USBES_HS_NONE;
                  st_q <= USBES_H_IDLE;
               end
            end
            default: st_q <= USBES_H_IDLE;
         endcase
      end
   end
endmodule

// ===== verification/usbes_link_checker.sv
// Protocol assertions on the link between host and device ends
`timescale 1ns/1ps
module usbes_link_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic bus_reset,
   input wire logic tok_valid,
   input wire logic tok_in,
   input wire logic [1:0] tok_ep,
   input wire logic tok_data1,
   input wire logic hs_valid,
   input wire usbes_pkg::usbes_hs_t hs_code
);
   import usbes_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ==========
   // Token and handshake timing
   property p_tok_answer;
      tok_valid && !bus_reset |=> hs_valid;
   endproperty
   a_tok_answer: assert property (p_tok_answer) else $error("no handshake after token");
   property p_hs_cause;
      hs_valid |-> $past(tok_valid) && !$past(bus_reset);
   endproperty
   a_hs_cause: assert property (p_hs_cause) else $error("handshake without token");
   property p_tok_gap;
      tok_valid |=> !tok_valid [*2];
   endproperty
   a_tok_gap: assert property (p_tok_gap) else $error("tokens too close");
   property p_hs_pulse;
      hs_valid |=> !hs_valid;
   endproperty
   a_hs_pulse: assert property (p_hs_pulse) else $error("handshake longer than one cycle");
   property p_tok_alone;
      tok_valid |-> !hs_valid;
   endproperty
   a_tok_alone: assert property (p_tok_alone) else $error("token overlaps handshake");
   // ==========
   // Bus reset framing
   property p_rst_pulse;
      bus_reset |=> !bus_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("bus reset longer than one cycle");
   property p_rst_excl;
      bus_reset |-> !tok_valid;
   endproperty
   a_rst_excl: assert property (p_rst_excl) else $error("bus reset with token");
   property p_rst_quiet;
      bus_reset |=> !hs_valid && !tok_valid;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("traffic right after bus reset");
   // ==========
   // Token fields and idle handshake code
   property p_tok_hold;
      tok_valid |=> $stable(tok_in) && $stable(tok_ep) && $stable(tok_data1);
   endproperty
   a_tok_hold: assert property (p_tok_hold) else $error("token fields moved during handshake");
   property p_hs_idle;
      !hs_valid |-> hs_code == USBES_HS_NONE;
   endproperty
   a_hs_idle: assert property (p_hs_idle) else $error("handshake code without handshake");
endmodule

// ===== verification/usb_endpoint_select_config_tb.sv
// Self-checking bench for both link ends and the register bus
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module usb_endpoint_select_config_tb;
   import usbes_pkg::*;
   logic sys_clk;
   logic nrst;
   logic [11:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] ep_ready;
   logic [3:0] ep_active;
   logic irq;
   logic cmd_valid;
   logic cmd_ready;
   logic cmd_reset;
   logic cmd_in;
   logic [1:0] cmd_ep;
   logic cmd_data1;
   logic res_valid;
   usbes_hs_t res_code;
   logic [7:0] cfg_m [4];
   logic [1:0] idx_m;
   logic [3:0] stat_m;
   logic [3:0] mask_m;
   logic [31:0] rd;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;

   usbes_link_if i_usbes_link_if ();
   usbes_dev i_usbes_dev (.sys_clk(sys_clk), .nrst(nrst), .link(i_usbes_link_if), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ep_ready(ep_ready),
      .ep_active(ep_active), .irq(irq));
   usbes_host i_usbes_host (.sys_clk(sys_clk), .nrst(nrst), .link(i_usbes_link_if), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_reset(cmd_reset), .cmd_in(cmd_in), .cmd_ep(cmd_ep), .cmd_data1(cmd_data1),
      .res_valid(res_valid), .res_code(res_code));
   usbes_link_checker i_usbes_link_checker (.sys_clk(sys_clk), .nrst(nrst),
      .bus_reset(i_usbes_link_if.bus_reset), .tok_valid(i_usbes_link_if.tok_valid),
      .tok_in(i_usbes_link_if.tok_in), .tok_ep(i_usbes_link_if.tok_ep), .tok_data1(i_usbes_link_if.tok_data1),
      .hs_valid(i_usbes_link_if.hs_valid), .hs_code(i_usbes_link_if.hs_code));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ==========
   // Verdict and hang guard
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Run takes a few thousand cycles; generous ceiling
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ==========
   // Bus, token and model tasks
   // Request held until the edge that sees waitrequest low; only the hang guard ends a wait
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
      bus(1'b1, a, d, be);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'h1);
      `CHK("register", {24'h0, e}, rd)
   endtask

   task automatic sel(input logic [1:0] e);
      wr(USBES_IDX_ADDR, {6'h0, e}, 4'h1);
      idx_m = e;
   endtask

   // Written zero clears a refusal flag, one leaves it
   task automatic cwr(input logic [7:0] v);
      wr(USBES_CTL_ADDR, v, 4'h1);
      cfg_m[idx_m] = (v & 8'hc7) | (cfg_m[idx_m] & 8'h08) | (cfg_m[idx_m] & v & 8'h30);
   endtask

   task automatic tok(input logic r, input logic i, input logic d, input usbes_hs_t e);
      cmd_valid <= 1'b1;
      cmd_reset <= r;
      cmd_in <= i;
      cmd_ep <= idx_m;
      cmd_data1 <= d;
      do begin
         @(posedge sys_clk);
      end while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      if (!r) begin
         do begin
            @(negedge sys_clk);
         end while (res_valid !== 1'b1);
         `CHK("handshake", e, res_code)
      end
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic pins();
      @(negedge sys_clk);
      `CHK("irq", |(stat_m & mask_m), irq)
      `CHK("active", {cfg_m[3][7], cfg_m[2][7], cfg_m[1][7], cfg_m[0][7]}, ep_active)
      @(posedge sys_clk);
   endtask

   function automatic usbes_hs_t exp_hs(logic [7:0] c, logic i, logic r);
      if (!c[USBES_ON_BIT]) return USBES_HS_NONE;
      if (c[1:0] != USBES_TYPE_CONTROL && c[USBES_DIR_BIT] != i) return USBES_HS_STALL;
      return r ? USBES_HS_ACK : USBES_HS_NAK;
   endfunction

   // ==========
   // Main sequence
   initial begin
      logic [1:0] e;
      logic [7:0] v;
      logic [3:0] rdy;
      logic i;
      logic d;
      usbes_hs_t h;
      nrst = 1'b0;
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      ep_ready = 4'h0;
      cmd_valid = 1'b0;
      cmd_reset = 1'b0;
      cmd_in = 1'b0;
      cmd_ep = 2'h0;
      cmd_data1 = 1'b0;
      cfg_m = '{default: 8'h00};
      idx_m = 2'h0;
      stat_m = 4'h0;
      mask_m = 4'h0;
      void'($urandom(61862));
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd_chk(USBES_IDX_ADDR, 8'h00);
      rd_chk(USBES_CTL_ADDR, USBES_CTL_RESET);
      rd_chk(USBES_IRQ_STAT_ADDR, 8'h00);
      rd_chk(USBES_IRQ_MASK_ADDR, 8'h00);
      $display("test reset values done");
      wr(USBES_IDX_ADDR, 8'hff, 4'h1);
      rd_chk(USBES_IDX_ADDR, USBES_IDX_MASK);
      wr(USBES_IDX_ADDR, 8'h01, 4'h0);
      rd_chk(USBES_IDX_ADDR, 8'h03);
      rd_chk(12'h008, 8'h00);
      for (int k = 0; k < 4; k++) begin
         sel(k[1:0]);
         cwr(8'h04 | k[7:0] | {k[0], 7'h0});
      end
      for (int k = 0; k < 4; k++) begin
         sel(k[1:0]);
         rd_chk(USBES_CTL_ADDR, cfg_m[k]);
      end
      pins();
      $display("test index select done");
      for (int k = 0; k < 60; k++) begin
         if (k % 15 == 0) begin
            tok(1'b1, 1'b0, 1'b0, USBES_HS_NONE);
            cfg_m = '{default: 8'h00};
            sel(2'h0);
            tok(1'b0, k[4], 1'b0, USBES_HS_NONE);
            cwr(8'h80);
         end
         e = 2'($urandom);
         sel(e);
         v = 8'($urandom) & 8'hc7;
         if (e == 2'h0) v[1:0] = USBES_TYPE_CONTROL;
         if (e == 2'h0) v[USBES_ON_BIT] = 1'b1;
         cwr(v);
         rdy = 4'($urandom);
         ep_ready <= rdy;
         i = 1'($urandom);
         d = 1'($urandom);
         h = exp_hs(cfg_m[e], i, rdy[e]);
         tok(1'b0, i, d, h);
         if (h == USBES_HS_NAK) begin
            cfg_m[e][i ? USBES_RIN_BIT : USBES_ROUT_BIT] = 1'b1;
            if (cfg_m[e][USBES_IEN_BIT]) stat_m[e] = 1'b1;
         end
         if (h == USBES_HS_ACK && !i) cfg_m[e][USBES_TGL_BIT] = d;
         rd_chk(USBES_CTL_ADDR, cfg_m[e]);
         cwr(cfg_m[e] | 8'h30);
         rd_chk(USBES_CTL_ADDR, cfg_m[e]);
         mask_m = 4'($urandom);
         wr(USBES_IRQ_MASK_ADDR, {4'h0, mask_m}, 4'h1);
         rd_chk(USBES_IRQ_STAT_ADDR, {4'h0, stat_m});
         pins();
         v = 8'($urandom);
         wr(USBES_IRQ_STAT_ADDR, v, 4'h1);
         stat_m = stat_m & ~v[3:0];
      end
      $display("test random traffic done");
      give_verdict();
   end
endmodule
